// >>> pkg/msd_pkg.sv
package msd_pkg;

    // command characters
    localparam logic [7:0] CH_A  = 8'h41;
    localparam logic [7:0] CH_T  = 8'h54;
    localparam logic [7:0] CH_E  = 8'h45;
    localparam logic [7:0] CH_H  = 8'h48;
    localparam logic [7:0] CH_I  = 8'h49;
    localparam logic [7:0] CH_L  = 8'h4C;
    localparam logic [7:0] CH_M  = 8'h4D;
    localparam logic [7:0] CH_O  = 8'h4F;
    localparam logic [7:0] CH_K  = 8'h4B;
    localparam logic [7:0] CH_R  = 8'h52;
    localparam logic [7:0] CH_0  = 8'h30;
    localparam logic [7:0] CH_CR = 8'h0D;

    // register map, byte addresses
    localparam int         ADR_W    = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;

    // field positions
    localparam int CFG_W          = 6;
    localparam int STAT_DATA_BIT  = 0;
    localparam int STAT_HELD_BIT  = 1;
    localparam int STAT_SPK_BIT   = 2;
    localparam int STAT_ERR_BIT   = 3;
    localparam int STAT_LINE_BIT  = 4;

    // speaker levels
    localparam logic [1:0] VOL_LOW  = 2'h0;
    localparam logic [1:0] VOL_MED  = 2'h1;
    localparam logic [1:0] VOL_HIGH = 2'h2;

    typedef enum logic [1:0] {
        SPEAKER_DISABLED,
        SPEAKER_UNTIL_CARRIER,
        SPEAKER_WHILE_OFFHOOK,
        SPEAKER_AFTER_DIAL_UNTIL_CARRIER
    } msd_spk_t;

    typedef enum logic [1:0] {RK_OK, RK_ERROR, RK_PRODUCT, RK_CHECKSUM} msd_rkind_t;

    // settings word, same layout as the control register
    typedef struct packed {
        msd_spk_t   spk_mode;
        logic [1:0] volume;
        logic       off_hook;
        logic       echo;
    } msd_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } msd_char_t;

    localparam msd_cfg_t CFG_RST = '{spk_mode: SPEAKER_UNTIL_CARRIER, volume: VOL_MED,
                                     off_hook: 1'b0, echo: 1'b1};

    // reply lengths in characters
    localparam logic [2:0] LEN_OK    = 3'h3;
    localparam logic [2:0] LEN_ERROR = 3'h6;
    localparam logic [2:0] LEN_IDENT = 3'h7;

endpackage : msd_pkg

// >>> src/msd_reply.sv
`timescale 1ns/100ps
module msd_reply (
    input  wire logic                clk_in,    // system clock
    input  wire logic                rst_in,    // sync reset, high
    input  wire logic                start_in,  // begin a reply
    input  wire msd_pkg::msd_rkind_t kind_in,   // which reply
    input  wire logic [7:0]          value_in,  // ident value
    input  wire logic                take_in,   // current char consumed
    output msd_pkg::msd_char_t       char_out,  // current reply char
    output logic                     busy_out,  // reply in progress
    output logic                     first_out  // first char showing
);
    import msd_pkg::*;

    logic       active_ff;
    logic [2:0] idx_ff;
    msd_rkind_t kind_ff;
    logic [7:0] val_ff;

    function automatic logic [2:0] len_of(input msd_rkind_t k);
        case (k)
            RK_OK:    len_of = LEN_OK;
            RK_ERROR: len_of = LEN_ERROR;
            default:  len_of = LEN_IDENT;
        endcase
    endfunction : len_of

    // ident replies: three decimal digits, then the OK line
    function automatic logic [7:0] char_at(input msd_rkind_t k, input logic [2:0] i,
                                           input logic [7:0] v);
        case (k)
            RK_OK: begin
                case (i)
                    3'h0:    char_at = CH_O;
                    3'h1:    char_at = CH_K;
                    default: char_at = CH_CR;
                endcase
            end
            RK_ERROR: begin
                case (i)
                    3'h0:    char_at = CH_E;
                    3'h1:    char_at = CH_R;
                    3'h2:    char_at = CH_R;
                    3'h3:    char_at = CH_O;
                    3'h4:    char_at = CH_R;
                    default: char_at = CH_CR;
                endcase
            end
            default: begin
                case (i)
                    3'h0:    char_at = CH_0 + v / 8'h64;
                    3'h1:    char_at = CH_0 + (v / 8'h0A) % 8'h0A;
                    3'h2:    char_at = CH_0 + v % 8'h0A;
                    3'h4:    char_at = CH_O;
                    3'h5:    char_at = CH_K;
                    default: char_at = CH_CR;
                endcase
            end
        endcase
    endfunction : char_at

    // sequencer; a new start overrides, the caller never overlaps them
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            active_ff <= 1'b0;
            idx_ff    <= 3'h0;
            kind_ff   <= RK_OK;
            val_ff    <= 8'h00;
        end else if (start_in) begin
            active_ff <= 1'b1;
            idx_ff    <= 3'h0;
            kind_ff   <= kind_in;
            val_ff    <= value_in;
        end else if (active_ff && take_in) begin
            if (idx_ff == len_of(kind_ff) - 3'h1) begin
                active_ff <= 1'b0;
            end
            idx_ff <= idx_ff + 3'h1;
        end
    end

    assign char_out  = '{valid: active_ff, data: char_at(kind_ff, idx_ff, val_ff)};
    assign busy_out  = active_ff;
    assign first_out = (idx_ff == 3'h0);

endmodule : msd_reply

// >>> src/msd_top.sv
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/100ps
// Function
// - In command state every received character is echoed back while echo is on, reset on.
// - The hook command value zero puts the line on hook, one off hook, on hook after reset.
// - Ident value zero replies the product code, one the checksum, two only OK.
// - Volume values zero and one give low, two medium, three high, medium after reset.
// - Speaker mode zero is off, one on until carrier, two on while off hook, one at reset.
// - Speaker mode three mutes during dialing, sounds after it, mutes once carrier is seen.
// - The online command resumes data mode for a call left through the escape sequence.
// - The online command value zero while on hook takes the line off hook and starts originate mode.
// - Online value one resumes the call and asks for a retrain, only at 2400 bps.
module msd_top #(
    parameter logic [7:0] PRODUCT_CODE  = 8'h2A,  // arbitrary value
    parameter logic [7:0] CHECKSUM_CODE = 8'h5C   // arbitrary value
) (
    input  wire logic                      CLOCK_IN,       // 125 MHz clock
    input  wire logic                      SYS_RST_IN,     // sync reset, high
    input  wire logic [msd_pkg::ADR_W-1:0] WB_ADR_IN,      // byte address
    input  wire logic [31:0]               WB_DAT_IN,      // write data
    input  wire logic [3:0]                WB_SEL_IN,      // byte lanes
    input  wire logic                      WB_WE_IN,       // write request
    input  wire logic                      WB_CYC_IN,      // bus cycle
    input  wire logic                      WB_STB_IN,      // strobe
    output logic [31:0]                    WB_DAT_OUT,     // read data
    output logic                           WB_ACK_OUT,     // acknowledge
    input  wire logic                      RX_VALID_IN,    // host char offered
    input  wire logic [7:0]                RX_CHAR_IN,     // host char
    output logic                           RX_READY_OUT,   // char accepted
    output logic                           TX_VALID_OUT,   // char to host
    output logic [7:0]                     TX_CHAR_OUT,    // echo or reply char
    input  wire logic                      TX_READY_IN,    // host took char
    input  wire logic                      ESCAPE_IN,      // escape seen, pulse
    input  wire logic                      CARRIER_IN,     // carrier detected
    input  wire logic                      DIALING_IN,     // dialer busy
    input  wire logic                      RATE_2400_IN,   // link at 2400 bps
    output logic                           OFF_HOOK_OUT,   // line switch off hook
    output logic                           SPEAKER_ON_OUT, // speaker gate
    output logic [1:0]                     VOLUME_OUT,     // speaker level
    output logic                           DATA_MODE_OUT,  // online data mode
    output logic                           ORIGINATE_OUT,  // originate start, pulse
    output logic                           RETRAIN_OUT     // retrain request, pulse
);
    import msd_pkg::*;

    typedef enum {ST_IDLE, ST_GOT_A, ST_CMD, ST_REPLY} msd_state_t;

    msd_state_t st_ff, nxt_st;
    msd_cfg_t   cfg_ff, ex_cfg;
    msd_rkind_t kind_ff, ex_kind, rep_kind;
    msd_char_t  rep_ch;
    logic [7:0] pend_ff, nxt_pend, ex_letter, up_ch, tx_char_ff;
    logic [3:0] ex_val;
    logic [31:0] rd_word, dat_ff;
    logic       ex_en, ex_err, ex_online, ex_orig, ex_retrain;
    logic       err_ff, go_online_ff, orig_ff, retrain_ff;
    logic       data_mode_ff, held_ff, speaker_ff, orig_out_ff, retrain_out_ff;
    logic       tx_valid_ff, rx_ready_ff, ack_ff;
    logic       rx_take, echo_now, tx_free, rep_take, rep_start, rep_busy, rep_first;
    logic       line_start, line_end, wb_req, wb_wr;

    function automatic logic [7:0] to_upper(input logic [7:0] c);
        to_upper = (c >= 8'h61 && c <= 8'h7A) ? (c & 8'hDF) : c;
    endfunction : to_upper

    function automatic logic hits(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] off);
        hits = (adr == off);
    endfunction : hits

    assign rx_take  = RX_VALID_IN && rx_ready_ff;
    assign echo_now = !data_mode_ff && cfg_ff.echo;
    assign tx_free  = !tx_valid_ff || TX_READY_IN;
    assign rep_take = rep_ch.valid && tx_free && !rx_take;
    assign up_ch    = to_upper(RX_CHAR_IN);
    assign line_end = (st_ff == ST_REPLY) && !rep_busy;

    // line parser; letters of other command groups pass silently
    always_comb begin
        nxt_st     = st_ff;
        nxt_pend   = pend_ff;
        ex_en      = 1'b0;
        ex_letter  = pend_ff;
        ex_val     = 4'h0;
        rep_start  = 1'b0;
        line_start = 1'b0;
        if (rx_take && !data_mode_ff) begin
            case (st_ff)
                ST_IDLE: begin
                    if (up_ch == CH_A) nxt_st = ST_GOT_A;
                end
                ST_GOT_A: begin
                    if (up_ch == CH_T) begin
                        nxt_st     = ST_CMD;
                        nxt_pend   = 8'h00;
                        line_start = 1'b1;
                    end else if (up_ch != CH_A) begin
                        nxt_st = ST_IDLE;
                    end
                end
                ST_CMD: begin
                    if (RX_CHAR_IN >= CH_0 && RX_CHAR_IN <= 8'h39 && pend_ff != 8'h00) begin
                        ex_en    = 1'b1;
                        ex_val   = RX_CHAR_IN[3:0];
                        nxt_pend = 8'h00;
                    end else if (RX_CHAR_IN == CH_CR) begin
                        ex_en     = (pend_ff != 8'h00);
                        nxt_pend  = 8'h00;
                        rep_start = 1'b1;
                        nxt_st    = ST_REPLY;
                    end else if (up_ch == CH_E || up_ch == CH_H || up_ch == CH_I ||
                                 up_ch == CH_L || up_ch == CH_M || up_ch == CH_O) begin
                        ex_en    = (pend_ff != 8'h00);
                        nxt_pend = up_ch;
                    end
                end
                default: ;
            endcase
        end
        if (line_end) nxt_st = ST_IDLE;
    end

    // one command with its value; a missing value counts as zero
    always_comb begin
        ex_cfg     = cfg_ff;
        ex_err     = 1'b0;
        ex_kind    = kind_ff;
        ex_online  = 1'b0;
        ex_orig    = 1'b0;
        ex_retrain = 1'b0;
        case (ex_letter)
            CH_E: begin
                if (ex_val <= 4'h1) ex_cfg.echo = ex_val[0];
                else ex_err = 1'b1;
            end
            CH_H: begin
                if (ex_val <= 4'h1) ex_cfg.off_hook = ex_val[0];
                else ex_err = 1'b1;
            end
            CH_I: begin
                case (ex_val)
                    4'h0:    ex_kind = RK_PRODUCT;
                    4'h1:    ex_kind = RK_CHECKSUM;
                    4'h2:    ex_kind = RK_OK;
                    default: ex_err = 1'b1;
                endcase
            end
            CH_L: begin
                if (ex_val <= 4'h1) ex_cfg.volume = VOL_LOW;
                else if (ex_val == 4'h2) ex_cfg.volume = VOL_MED;
                else if (ex_val == 4'h3) ex_cfg.volume = VOL_HIGH;
                else ex_err = 1'b1;
            end
            CH_M: begin
                if (ex_val <= 4'h3) ex_cfg.spk_mode = msd_spk_t'(ex_val[1:0]);
                else ex_err = 1'b1;
            end
            CH_O: begin
                if (ex_val == 4'h0 && !cfg_ff.off_hook) begin
                    ex_cfg.off_hook = 1'b1;
                    ex_online       = 1'b1;
                    ex_orig         = 1'b1;
                end else if (ex_val <= 4'h1 && held_ff) begin
                    ex_online  = 1'b1;
                    ex_retrain = ex_val[0] && RATE_2400_IN;
                end else begin
                    ex_err = 1'b1;
                end
            end
            default: ;
        endcase
    end

    // an error anywhere on the line turns the reply into an error reply
    assign rep_kind = (err_ff || (ex_en && ex_err)) ? RK_ERROR : (ex_en ? ex_kind : kind_ff);

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            st_ff   <= ST_IDLE;
            pend_ff <= 8'h00;
        end else begin
            st_ff   <= nxt_st;
            pend_ff <= nxt_pend;
        end
    end

    // per-line results, cleared as the next line opens
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN || line_start) begin
            err_ff       <= 1'b0;
            kind_ff      <= RK_OK;
            go_online_ff <= 1'b0;
            orig_ff      <= 1'b0;
            retrain_ff   <= 1'b0;
        end else if (ex_en) begin
            err_ff       <= err_ff | ex_err;
            kind_ff      <= ex_kind;
            go_online_ff <= go_online_ff | ex_online;
            orig_ff      <= orig_ff | ex_orig;
            retrain_ff   <= retrain_ff | ex_retrain;
        end
    end

    // settings; a command wins over a bus write in the same cycle
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            cfg_ff <= CFG_RST;
        end else if (ex_en) begin
            if (!ex_err) cfg_ff <= ex_cfg;
        end else if (wb_wr && hits(WB_ADR_IN, REG_CTRL) && WB_SEL_IN[0]) begin
            cfg_ff <= msd_cfg_t'(WB_DAT_IN[CFG_W-1:0]);
        end
    end

    // call state; actions wait for the reply so the host sees OK first
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            data_mode_ff   <= 1'b0;
            held_ff        <= 1'b0;
            orig_out_ff    <= 1'b0;
            retrain_out_ff <= 1'b0;
        end else begin
            orig_out_ff    <= line_end && go_online_ff && orig_ff && !err_ff;
            retrain_out_ff <= line_end && go_online_ff && retrain_ff && !err_ff;
            if (data_mode_ff && ESCAPE_IN) begin
                data_mode_ff <= 1'b0;
                held_ff      <= 1'b1;
            end else if (line_end && go_online_ff && !err_ff) begin
                data_mode_ff <= 1'b1;
                held_ff      <= 1'b0;
            end else if (!cfg_ff.off_hook) begin
                held_ff <= 1'b0;
            end
        end
    end

    // speaker gate by mode
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            speaker_ff <= 1'b0;
        end else begin
            case (cfg_ff.spk_mode)
                SPEAKER_DISABLED:      speaker_ff <= 1'b0;
                SPEAKER_UNTIL_CARRIER: speaker_ff <= cfg_ff.off_hook && !CARRIER_IN;
                SPEAKER_WHILE_OFFHOOK: speaker_ff <= cfg_ff.off_hook;
                default: speaker_ff <= cfg_ff.off_hook && !DIALING_IN && !CARRIER_IN;
            endcase
        end
    end

    msd_reply msd_reply_i (
        .clk_in   (CLOCK_IN),
        .rst_in   (SYS_RST_IN),
        .start_in (rep_start),
        .kind_in  (rep_kind),
        .value_in ((rep_kind == RK_CHECKSUM) ? CHECKSUM_CODE : PRODUCT_CODE),
        .take_in  (rep_take),
        .char_out (rep_ch),
        .busy_out (rep_busy),
        .first_out(rep_first)
    );

    // host stream; echo has the slot, reply chars fill it otherwise
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            tx_valid_ff <= 1'b0;
            tx_char_ff  <= 8'h00;
            rx_ready_ff <= 1'b0;
        end else begin
            if (rx_take && echo_now) begin
                tx_valid_ff <= 1'b1;
                tx_char_ff  <= RX_CHAR_IN;
            end else if (rep_take) begin
                tx_valid_ff <= 1'b1;
                tx_char_ff  <= rep_ch.data;
            end else if (TX_READY_IN) begin
                tx_valid_ff <= 1'b0;
            end
            // one char at a time, so an echo never needs a buffer
            rx_ready_ff <= !rx_take && !(tx_valid_ff && !TX_READY_IN) && !rep_start &&
                           !rep_busy && nxt_st != ST_REPLY;
        end
    end

    // wishbone slave: ack one cycle after the strobe, write at the ack edge
    assign wb_req = WB_CYC_IN && WB_STB_IN;
    assign wb_wr  = wb_req && WB_WE_IN && ack_ff;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hits(WB_ADR_IN, REG_CTRL)) begin
            rd_word[CFG_W-1:0] = cfg_ff;
        end else if (hits(WB_ADR_IN, REG_STAT)) begin
            rd_word[STAT_DATA_BIT] = data_mode_ff;
            rd_word[STAT_HELD_BIT] = held_ff;
            rd_word[STAT_SPK_BIT]  = speaker_ff;
            rd_word[STAT_ERR_BIT]  = err_ff;
            rd_word[STAT_LINE_BIT] = (st_ff == ST_CMD);
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= wb_req && !ack_ff;
            if (wb_req && !ack_ff) dat_ff <= rd_word;
        end
    end

    assign WB_ACK_OUT     = ack_ff;
    assign WB_DAT_OUT     = dat_ff;
    assign RX_READY_OUT   = rx_ready_ff;
    assign TX_VALID_OUT   = tx_valid_ff;
    assign TX_CHAR_OUT    = tx_char_ff;
    assign OFF_HOOK_OUT   = cfg_ff.off_hook;
    assign SPEAKER_ON_OUT = speaker_ff;
    assign VOLUME_OUT     = cfg_ff.volume;
    assign DATA_MODE_OUT  = data_mode_ff;
    assign ORIGINATE_OUT  = orig_out_ff;
    assign RETRAIN_OUT    = retrain_out_ff;

    // checks
    default clocking cb_chk @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_cr_taken;
        rx_take && !data_mode_ff && st_ff == ST_CMD && RX_CHAR_IN == CH_CR;
    endsequence
    sequence s_hook_on;
        ex_en && ex_letter == CH_H && ex_val == 4'h0;
    endsequence

    a_echo_back:
        assert property (rx_take && echo_now |=> TX_VALID_OUT && TX_CHAR_OUT == $past(RX_CHAR_IN))
        else $error("received char not echoed");
    a_echo_quiet:
        assert property (rx_take && !echo_now |=> !TX_VALID_OUT)
        else $error("char echoed with echo off");
    a_hook_on:
        assert property (s_hook_on |=> !OFF_HOOK_OUT) else $error("hook command ignored");
    a_ident_digit:
        assert property (rep_start && rep_kind == RK_PRODUCT |=>
                         rep_first && rep_ch.data == CH_0 + PRODUCT_CODE / 8'h64)
        else $error("product reply starts wrong");
    a_volume_low:
        assert property (ex_en && !ex_err && ex_letter == CH_L && ex_val <= 4'h1 |=>
                         VOLUME_OUT == VOL_LOW) else $error("low volume not set");
    a_speaker_off:
        assert property (cfg_ff.spk_mode == SPEAKER_DISABLED |=> !SPEAKER_ON_OUT)
        else $error("speaker on while disabled");
    a_dial_mute:
        assert property (cfg_ff.spk_mode == SPEAKER_AFTER_DIAL_UNTIL_CARRIER &&
                         (DIALING_IN || CARRIER_IN) |=> !SPEAKER_ON_OUT)
        else $error("speaker not muted");
    a_online_resume:
        assert property ($rose(DATA_MODE_OUT) |-> $past(line_end) && $past(go_online_ff))
        else $error("data mode without online command");
    a_orig_offhook:
        assert property (ORIGINATE_OUT |-> OFF_HOOK_OUT && DATA_MODE_OUT)
        else $error("originate while on hook");
    a_retrain_online:
        assert property (RETRAIN_OUT |-> DATA_MODE_OUT && !$past(DATA_MODE_OUT))
        else $error("retrain outside resume");
    a_bad_value:
        assert property (ex_en && ex_err |=> cfg_ff == $past(cfg_ff) && err_ff)
        else $error("bad value changed settings");
    a_reply_start:
        assert property (s_cr_taken |=> st_ff == ST_REPLY && rep_busy ##1 !RX_READY_OUT)
        else $error("return did not start reply");

endmodule : msd_top

// >>> bench/msd_host.sv
`timescale 1ns/100ps
module msd_host (
    input  wire logic       clk_in,       // system clock
    input  wire logic       rx_ready_in,  // device takes char
    input  wire logic       tx_valid_in,  // device char valid
    input  wire logic [7:0] tx_char_in,   // device char
    output logic            rx_valid_out, // char offered
    output logic [7:0]      rx_char_out,  // offered char
    output logic            tx_ready_out  // host always takes
);
    byte got[$];
    initial begin
        rx_valid_out = 1'b0;
        rx_char_out  = 8'hFF;
        tx_ready_out = 1'b1;
    end
    // everything the device hands back, echo and replies alike
    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out) got.push_back(tx_char_in);
    end
    // each line opens with the prefix and closes with a return
    task automatic send_line(input string body);
        string s;
        s = {"AT", body, "\r"};
        // valid stays up from char to char, so it is never set twice in one step
        for (int i = 0; i < s.len(); i++) begin
            rx_valid_out <= 1'b1;
            rx_char_out  <= s[i];
            do @(posedge clk_in); while (rx_ready_in !== 1'b1);
        end
        rx_valid_out <= 1'b0;
        rx_char_out  <= ~s[s.len()-1]; // released line shows no stale char
        // reply holds input off; wait until it is taken again
        repeat (2) @(posedge clk_in);
        for (int n = 0; n < 300 && rx_ready_in !== 1'b1; n++) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
    endtask : send_line
endmodule : msd_host

// >>> bench/msd_top_test.sv
`timescale 1ns/100ps
module msd_top_test;
    import msd_pkg::*;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
    logic esc = 1'b0, car = 1'b0, dial = 1'b0, r2400 = 1'b0;
    logic rxv, rxr, txv, offh, spk, dmode, orig, rtr, txr;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdo, rdat;
    logic [7:0]  rxc, txc;
    logic [1:0]  vol;
    logic [1:0]  lv[4] = '{VOL_LOW, VOL_LOW, VOL_MED, VOL_HIGH};
    int bad_count = 0, n_checks = 0, n_orig = 0, n_rtr = 0;
    always #4 clk = ~clk;
    msd_top msd_top_i (.CLOCK_IN(clk), .SYS_RST_IN(rst), .WB_ADR_IN(adr), .WB_DAT_IN(wdat),
        .WB_SEL_IN(4'hF), .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_DAT_OUT(rdo),
        .WB_ACK_OUT(ack), .RX_VALID_IN(rxv), .RX_CHAR_IN(rxc), .RX_READY_OUT(rxr),
        .TX_VALID_OUT(txv), .TX_CHAR_OUT(txc), .TX_READY_IN(txr), .ESCAPE_IN(esc),
        .CARRIER_IN(car), .DIALING_IN(dial), .RATE_2400_IN(r2400), .OFF_HOOK_OUT(offh),
        .SPEAKER_ON_OUT(spk), .VOLUME_OUT(vol), .DATA_MODE_OUT(dmode),
        .ORIGINATE_OUT(orig), .RETRAIN_OUT(rtr));
    msd_host msd_host_i (.clk_in(clk), .rx_ready_in(rxr), .tx_valid_in(txv),
        .tx_char_in(txc), .rx_valid_out(rxv), .rx_char_out(rxc), .tx_ready_out(txr));
    // pulses last one cycle, so they are counted here
    always @(posedge clk) begin
        n_orig += (orig === 1'b1);
        n_rtr  += (rtr === 1'b1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        adr <= a; we <= w; wdat <= d; cyc <= 1'b1; stb <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = rdo;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic line(input string body, input string exp);
        msd_host_i.got.delete();
        msd_host_i.send_line(body);
        check(msd_host_i.got.size(), exp.len());
        for (int i = 0; i < exp.len(); i++)
            check(i < msd_host_i.got.size() ? msd_host_i.got[i] : 8'hXX, exp[i]);
    endtask : line
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // a hang costs one mismatch; the run is far shorter than this
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({offh, vol}, {1'b0, VOL_MED});
        wb(REG_CTRL, 1'b0, 32'h0); check(rdat[5:0], CFG_RST);
        wb(REG_CTRL, 1'b1, 32'h19); check(vol, VOL_HIGH);
        wb(4'h8, 1'b0, 32'h0); check(rdat, 32'h0);
        line("H1", "ATH1\rOK\r"); check(offh, 1'b1);
        line("E0", "ATE0OK\r");
        foreach (lv[i]) begin
            line($sformatf("L%0d", i), "OK\r"); check(vol, lv[i]);
        end
        line("L4", "ERROR\r"); check(vol, VOL_HIGH);
        line("I0", "042\rOK\r");
        line("I1", "092\rOK\r");
        line("I2", "OK\r");
        line("M2", "OK\r"); check(spk, 1'b1);
        line("M0", "OK\r"); check(spk, 1'b0);
        dial <= 1'b1; line("M3", "OK\r"); check(spk, 1'b0);
        dial <= 1'b0; repeat (3) @(posedge clk); check(spk, 1'b1);
        car <= 1'b1; repeat (3) @(posedge clk); check(spk, 1'b0);
        line("M1", "OK\r"); check(spk, 1'b0);
        car <= 1'b0; repeat (3) @(posedge clk); check(spk, 1'b1);
        line("H0O", "OK\r"); check({dmode, offh, n_orig[29:0]}, {2'b11, 30'd1});
        esc <= 1'b1; @(posedge clk); esc <= 1'b0; wb(REG_STAT, 1'b0, 32'h0);
        check(rdat[STAT_HELD_BIT], 1'b1);
        r2400 <= 1'b1; line("O1", "OK\r"); check({dmode, n_rtr[30:0]}, {1'b1, 31'd1});
        stop_test();
    end
endmodule : msd_top_test
